// File: fps_pkg.sv
// Purpose: shared constants and types for the flash protection host controller
// Assumes: 20 MHz clock, 16-bit flash data bus, word addressing
// Notes: command codes are plain parameters; op encodings are fixed in fps_op_t
package fps_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	// bus cycle timing, in ns and in clocks (least times round up)
	localparam int CLK_NS = 50;
	localparam int WE_LOW_NS = 100;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_ACC_NS = 100;
	localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int GLITCH_NS = 3;
	localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] CNT_RST = 4'h0;
	// secured region geometry
	localparam logic [ADDR_W-1:0] SEC_LAST_WORD = 22'h00007F;
	localparam logic [ADDR_W-1:0] SERIAL_LAST_WORD = 22'h000007;
	localparam int LOCK_BIT_POS = 7;
	// unlock sequence addresses and data (word mode, plain defaults)
	localparam logic [ADDR_W-1:0] UNLK_A1 = 22'h000555;
	localparam logic [ADDR_W-1:0] UNLK_A2 = 22'h0002AA;
	localparam logic [DATA_W-1:0] UNLK_D1 = 16'h00AA;
	localparam logic [DATA_W-1:0] UNLK_D2 = 16'h0055;
	localparam logic [DATA_W-1:0] CMD_ENTER = 16'h0088;
	localparam logic [DATA_W-1:0] CMD_EXIT1 = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_EXIT2 = 16'h0000;
	localparam logic [DATA_W-1:0] CMD_PROG = 16'h00A0;
	localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROG = 3'h1,
		OP_ENTER = 3'h2,
		OP_EXIT = 3'h3,
		OP_RESET = 3'h4
	} fps_op_t;

	typedef struct packed {
		fps_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fps_req_t;

	// flash control pins, all active low
	typedef struct packed {
		logic ceN;
		logic oeN;
		logic weN;
	} fps_ctl_t;
endpackage : fps_pkg

// File: fps_host.sv
// Purpose: host controller driving the flash pins for protection and secured
//          region operations
// Assumes: flash data pins are two-way; supply lockout and power up
//          are flags supplied by the board logic; high voltage on reset is an output
// Notes: one request at a time; req is taken whenever idle with reqValid high, ready is not checked
`timescale 1ns/1ps
// Function
// - temporary unprotect only while reset pin held at high voltage
// - after enter sequence, region reads appear at first sector addresses
// - lock by entering region then protect algorithm, reset high or HV
// - alternatively lock with alternate sector protection after entering
// - host must issue exit sequence before touching rest of array
// - write only with chip and write enable low, output enable high
module fps_host import fps_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// user request side
	input wire logic reqValid,
	input wire fps_req_t req,
	output logic reqReady,
	output logic rspValid,
	output logic [DATA_W-1:0] rspData,
	output logic rspLockBit,
	output logic rspRefused,
	output logic inRegion,
	// user protection controls
	input wire logic wantUnprotect,
	input wire logic wantWrProtect,
	// board condition flags
	input wire logic supplyLowIn,
	input wire logic powerUpIn,
	// flash pins
	output fps_ctl_t flashCtl,
	output logic [ADDR_W-1:0] flashAddr,
	output logic [DATA_W-1:0] flashDout,
	output logic flashDoe,
	input wire logic [DATA_W-1:0] flashDin,
	output logic highVoltReset,
	output logic writeProtectN
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_WLOW = 3'h2,
		ST_WHIGH = 3'h3,
		ST_RLOW = 3'h4,
		ST_DONE = 3'h5
	} fps_st_t;

	////////////////////////////////////////////////////////////////////////
	// pin input synchronisers
	logic [DATA_W-1:0] dinMeta_r, dinSync_r;
	logic lowMeta_r, lowSync_r, pupMeta_r, pupSync_r;
	always_ff @(posedge clk) begin
		dinMeta_r <= flashDin;
		dinSync_r <= dinMeta_r;
		lowMeta_r <= supplyLowIn;
		lowSync_r <= lowMeta_r;
		pupMeta_r <= powerUpIn;
		pupSync_r <= pupMeta_r;
	end

	// writes are pointless while supply is low or powering up
	// both conditions arrive as plain board flags
	logic writeBlocked;
	assign writeBlocked = lowSync_r | pupSync_r;

	////////////////////////////////////////////////////////////////////////
	// sequence table: cycles per op
	fps_st_t state_r;
	fps_req_t cur_r;
	logic [2:0] step_r;
	logic [3:0] cnt_r;
	logic [2:0] nSteps;
	logic [ADDR_W-1:0] stepAddr;
	logic [DATA_W-1:0] stepData;

	// unlock cycles precede every command except the single-cycle reset command
	// the standard program sequence also serves the region
	always_comb begin
		stepAddr = UNLK_A1;
		stepData = CMD_RESET;
		nSteps = 3'h1;
		unique case (cur_r.op)
			OP_READ: begin
				stepAddr = cur_r.addr;
				stepData = '0;
			end
			OP_RESET: begin
				stepAddr = cur_r.addr;
				stepData = CMD_RESET;
			end
			OP_ENTER, OP_PROG: begin
				nSteps = (cur_r.op == OP_PROG) ? 3'h4 : 3'h3;
				unique case (step_r)
					3'h0: begin
						stepAddr = UNLK_A1;
						stepData = UNLK_D1;
					end
					3'h1: begin
						stepAddr = UNLK_A2;
						stepData = UNLK_D2;
					end
					3'h2: begin
						stepAddr = UNLK_A1;
						stepData = (cur_r.op == OP_PROG) ? CMD_PROG : CMD_ENTER;
					end
					default: begin
						stepAddr = cur_r.addr;
						stepData = cur_r.data;
					end
				endcase
			end
			OP_EXIT: begin
				nSteps = 3'h4;
				unique case (step_r)
					3'h0: begin
						stepAddr = UNLK_A1;
						stepData = UNLK_D1;
					end
					3'h1: begin
						stepAddr = UNLK_A2;
						stepData = UNLK_D2;
					end
					3'h2: begin
						stepAddr = UNLK_A1;
						stepData = CMD_EXIT1;
					end
					default: begin
						stepAddr = '0;
						stepData = CMD_EXIT2;
					end
				endcase
			end
			default: begin
				stepAddr = UNLK_A1;
				stepData = CMD_RESET;
			end
		endcase
	end

	// a programming write that must be refused by the host itself
	logic protRefuse;
	assign protRefuse = (req.op == OP_PROG) && inRegion
		&& (req.addr <= SERIAL_LAST_WORD) && rspLockBit;

	////////////////////////////////////////////////////////////////////////
	// bus cycle state machine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cur_r <= '0;
			step_r <= 3'h0;
			cnt_r <= CNT_RST;
		end else begin
			unique case (state_r)
				ST_IDLE: if (reqValid) begin
					cur_r <= req;
					step_r <= 3'h0;
					cnt_r <= CNT_RST;
					if (writeBlocked && req.op != OP_READ)
						state_r <= ST_DONE;
					else if (protRefuse)
						state_r <= ST_DONE;
					else
						state_r <= ST_SETUP;
				end
				ST_SETUP: begin
					cnt_r <= CNT_RST;
					state_r <= (cur_r.op == OP_READ) ? ST_RLOW : ST_WLOW;
				end
				// held low well past the glitch filter
				ST_WLOW: if (cnt_r == 4'(WE_LOW_CYC + GLITCH_CYC - 1)) begin
					cnt_r <= CNT_RST;
					state_r <= ST_WHIGH;
				end else begin
					cnt_r <= cnt_r + 4'h1;
				end
				ST_WHIGH: if (step_r + 3'h1 >= nSteps) begin
					state_r <= ST_DONE;
				end else begin
					step_r <= step_r + 3'h1;
					state_r <= ST_SETUP;
				end
				ST_RLOW: if (cnt_r == 4'(RD_ACC_CYC + 2)) begin
					state_r <= ST_DONE; // extra two for the synchroniser
				end else begin
					cnt_r <= cnt_r + 4'h1;
				end
				ST_DONE: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// pin drive: write strobes keep output enable high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flashCtl <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
			flashAddr <= '0;
			flashDout <= '0;
			flashDoe <= 1'b0;
		end else begin
			flashAddr <= stepAddr;
			flashDout <= stepData;
			flashDoe <= (state_r == ST_SETUP && cur_r.op != OP_READ)
				|| state_r == ST_WLOW;
			flashCtl.ceN <= !(state_r == ST_WLOW || state_r == ST_RLOW);
			flashCtl.weN <= !(state_r == ST_WLOW);
			flashCtl.oeN <= !(state_r == ST_RLOW);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// responses and region tracking
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rspValid <= 1'b0;
			rspData <= '0;
			rspRefused <= 1'b0;
			reqReady <= 1'b0;
		end else begin
			rspValid <= (state_r == ST_DONE);
			reqReady <= (state_r == ST_IDLE) && !reqValid;
			if (state_r == ST_IDLE && reqValid)
				rspRefused <= (writeBlocked && req.op != OP_READ) || protRefuse;
			if (state_r == ST_RLOW)
				rspData <= dinSync_r;
		end
	end

	// overlay follows enter/exit; hardware reset or power loss drops it
	// a reset command only returns to read mode, the overlay stays
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			inRegion <= 1'b0;
			rspLockBit <= 1'b0;
		end else begin
			if (lowSync_r || pupSync_r)
				inRegion <= 1'b0;
			else if (state_r == ST_DONE && !rspRefused
				&& cur_r.op == OP_ENTER)
				inRegion <= 1'b1;
			else if (state_r == ST_DONE && cur_r.op == OP_EXIT)
				inRegion <= 1'b0;
			// lock state read from bit 7 of a region read
			if (state_r == ST_RLOW && inRegion)
				rspLockBit <= dinSync_r[LOCK_BIT_POS];
		end
	end

	// high voltage and write-protect pin levels
	// programs are never refused for high voltage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			highVoltReset <= 1'b0;
			writeProtectN <= 1'b1;
		end else begin
			highVoltReset <= wantUnprotect && !lowSync_r;
			writeProtectN <= !wantWrProtect;
		end
	end
endmodule : fps_host

// File: fps_host_properties.sv
// Purpose: pin timing checks on the flash host
// Assumes: bound to fps_host, one clock domain
// Notes: strobe width is the fixed 3-cycle low pulse
`timescale 1ns/1ps
module fps_host_properties import fps_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// watched ports
	input wire logic rspValid,
	input wire logic rspRefused,
	input wire fps_ctl_t flashCtl,
	input wire logic flashDoe,
	input wire logic highVoltReset,
	input wire logic writeProtectN,
	input wire logic wantUnprotect,
	input wire logic wantWrProtect
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	//////////////////////////////////////////////////////////////////////////
	// one write strobe: low three cycles, then high
	sequence sWeLow;
		!flashCtl.weN [*3] ##1 flashCtl.weN;
	endsequence
	AST_WE_WIDTH: assert property ($fell(flashCtl.weN) |-> sWeLow)
		else $error("write strobe width wrong");
	AST_WE_QUAL: assert property (!flashCtl.weN |->
		!flashCtl.ceN && flashCtl.oeN && flashDoe) else $error("bad write");
	AST_OE_NODRV: assert property (!flashCtl.oeN |->
		!flashDoe && flashCtl.weN) else $error("drive during read");
	// refused work leaves the pins quiet
	AST_REFUSE_QUIET: assert property (rspValid && rspRefused |->
		$past(flashCtl.ceN) && $past(flashCtl.weN)) else $error("pins moved");
	AST_HV_ONLY: assert property (!wantUnprotect [*2] |->
		!highVoltReset) else $error("high voltage unasked");
	AST_HV_FOLLOW: assert property (wantUnprotect [*2] |->
		highVoltReset) else $error("high voltage missing");
	AST_WP_LOW: assert property (wantWrProtect [*2] |->
		!writeProtectN) else $error("protect not driven");
	AST_WP_HIGH: assert property (!wantWrProtect [*2] |->
		writeProtectN) else $error("protect stuck");
endmodule : fps_host_properties
bind fps_host fps_host_properties fps_host_properties_inst (.clk, .rst_n,
	.rspValid, .rspRefused, .flashCtl, .flashDoe, .highVoltReset,
	.writeProtectN, .wantUnprotect, .wantWrProtect);

// File: fps_flash_model.sv
// Purpose: behavioural flash device on the host pins
// Assumes: 128-word array window, erased to all ones
// Notes: no stored group protection; host reset does not reach it
`timescale 1ns/1ps
module fps_flash_model import fps_pkg::*; #(
	parameter bit LOCKED = 1'b1 // factory locked region
) (
	// pins from host
	input wire fps_ctl_t flashCtl,
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic [DATA_W-1:0] flashDout,
	input wire logic writeProtectN,
	// data to host
	output logic [DATA_W-1:0] flashDin
);
	logic [DATA_W-1:0] arr [0:127];
	logic [DATA_W-1:0] sec [0:127];
	logic [DATA_W-1:0] rdData, lastOut;
	logic [2:0] step;
	logic region, rd, inSec;
	initial begin
		foreach (arr[i]) arr[i] = 16'hFFFF;
		foreach (sec[i]) sec[i] = 16'h5A00 + 16'(i);
		step = 3'h0;
		region = 1'b0;
		lastOut = 16'h0000;
	end
	//////////////////////////////////////////////////////////////////////////
	// commands latch on strobe fall; a broken unlock pair drops to idle
	always @(negedge flashCtl.weN) begin
		if (!flashCtl.ceN && flashCtl.oeN) begin
			case (step)
			3'h0: step = (flashAddr == UNLK_A1 && flashDout == UNLK_D1) ? 3'h1 : 3'h0;
			3'h1: step = (flashAddr == UNLK_A2 && flashDout == UNLK_D2) ? 3'h2 : 3'h0;
			3'h2: begin
				region = region | (flashDout == CMD_ENTER);
				step = (flashDout == CMD_PROG) ? 3'h4 : 3'(flashDout == CMD_EXIT1) * 3'h3;
			end
			3'h3: begin
				region = region & (flashDout != CMD_EXIT2);
				step = 3'h0;
			end
			default: begin
				// locked region never changes; edge group obeys write-protect
				if (inSec && !LOCKED) sec[flashAddr[6:0]] &= flashDout;
				else if (!inSec && (writeProtectN || flashAddr[21:15] != 7'h00))
					arr[flashAddr[6:0]] &= flashDout;
				step = 3'h0;
			end
			endcase
		end
	end
	// read path: released bus shows the inverse of the last word
	assign rd = !flashCtl.ceN && !flashCtl.oeN;
	assign inSec = region && flashAddr <= SEC_LAST_WORD;
	always_comb begin
		rdData = inSec ? sec[flashAddr[6:0]] : arr[flashAddr[6:0]];
		if (inSec) rdData[LOCK_BIT_POS] = LOCKED;
	end
	always @(negedge rd) lastOut = ~rdData;
	assign flashDin = rd ? rdData : lastOut;
endmodule : fps_flash_model

// File: tb_fps_host.sv
// Purpose: directed bench for the flash host controller
// Assumes: locked model part, 50 ns clock
// Notes: mid-run reset comes last, the model keeps its overlay
`timescale 1ns/1ps
module tb_fps_host import fps_pkg::*;;
	logic clk, rst_n, reqValid, reqReady, rspValid, rspLockBit, rspRefused;
	logic inRegion, wantUnprotect, wantWrProtect, supplyLowIn, powerUpIn;
	logic flashDoe, highVoltReset, writeProtectN;
	logic [DATA_W-1:0] rspData, flashDout, flashDin;
	logic [ADDR_W-1:0] flashAddr;
	fps_req_t req;
	fps_ctl_t flashCtl;
	int nFail, checksDone;
	fps_host fps_host_inst (.clk, .rst_n, .reqValid, .req, .reqReady,
		.rspValid, .rspData, .rspLockBit, .rspRefused, .inRegion,
		.wantUnprotect, .wantWrProtect, .supplyLowIn, .powerUpIn, .flashCtl,
		.flashAddr, .flashDout, .flashDoe, .flashDin, .highVoltReset,
		.writeProtectN);
	fps_flash_model fps_flash_model_inst (.flashCtl, .flashAddr, .flashDout,
		.writeProtectN, .flashDin);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic completeRun;
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : completeRun
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		checksDone++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// one request, bounded wait for ready and for the answer
	task automatic doOp(fps_op_t op, logic [21:0] a, logic [15:0] d);
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		req = '{op, a, d};
		reqValid = 1'b1;
		tick(1);
		while (rspValid !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		reqValid = 1'b0;
		if (n >= 200) begin
			nFail++;
			$display("mismatch request wait expected %0d seen %0d", 200, n);
			completeRun();
		end
	endtask : doOp
	//////////////////////////////////////////////////////////////////////////
	task automatic tRegion;
		doOp(OP_PROG, 22'h000010, 16'h1234);
		doOp(OP_READ, 22'h000010, 16'h0000);
		check("plain read", 16'h1234, rspData);
		doOp(OP_ENTER, 22'h000000, 16'h0000);
		check("overlay", 16'h0001, 16'(inRegion));
		doOp(OP_READ, 22'h000003, 16'h0000);
		check("region word", 16'h5A83, rspData);
		check("lock bit", 16'h0001, 16'(rspLockBit));
		doOp(OP_PROG, 22'h000003, 16'h0000);
		check("serial refuse", 16'h0001, 16'(rspRefused));
		doOp(OP_EXIT, 22'h000000, 16'h0000);
		check("exit", 16'h0000, 16'(inRegion));
		doOp(OP_READ, 22'h000003, 16'h0000);
		check("normal map", 16'hFFFF, rspData);
		$display("test region done");
	endtask : tRegion
	task automatic tProtect;
		wantWrProtect = 1'b1;
		tick(2);
		check("wp pin", 16'h0000, 16'(writeProtectN));
		doOp(OP_PROG, 22'h000011, 16'h0000);
		wantWrProtect = 1'b0;
		doOp(OP_READ, 22'h000011, 16'h0000);
		check("wp blocked", 16'hFFFF, rspData);
		doOp(OP_PROG, 22'h000011, 16'h00F0);
		doOp(OP_READ, 22'h000011, 16'h0000);
		check("wp released", 16'h00F0, rspData);
		wantUnprotect = 1'b1;
		tick(2);
		check("hv on", 16'h0001, 16'(highVoltReset));
		doOp(OP_PROG, 22'h000013, 16'h0F0F);
		check("hv prog", 16'h0000, 16'(rspRefused));
		wantWrProtect = 1'b1;
		tick(2);
		check("wp in hv", 16'h0000, 16'(writeProtectN));
		check("hv kept", 16'h0001, 16'(highVoltReset));
		wantUnprotect = 1'b0;
		wantWrProtect = 1'b0;
		tick(2);
		check("hv off", 16'h0000, 16'(highVoltReset));
		check("wp off", 16'h0001, 16'(writeProtectN));
		$display("test protect done");
	endtask : tProtect
	task automatic tInhibit;
		supplyLowIn = 1'b1;
		tick(3);
		doOp(OP_PROG, 22'h000012, 16'h0000);
		check("low supply", 16'h0001, 16'(rspRefused));
		supplyLowIn = 1'b0;
		powerUpIn = 1'b1;
		tick(3);
		doOp(OP_PROG, 22'h000012, 16'h0000);
		check("power up", 16'h0001, 16'(rspRefused));
		powerUpIn = 1'b0;
		tick(3);
		doOp(OP_READ, 22'h000012, 16'h0000);
		check("no write", 16'hFFFF, rspData);
		doOp(OP_ENTER, 22'h000000, 16'h0000);
		doOp(OP_RESET, 22'h000000, 16'h0000);
		check("reset cmd keeps", 16'h0001, 16'(inRegion));
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(1);
		check("reset map", 16'h0000, 16'(inRegion));
		$display("test inhibit done");
	endtask : tInhibit
	// main sequence; inputs move 1 ns after the edge
	initial begin
		{rst_n, reqValid, wantUnprotect, wantWrProtect} = 4'h0;
		{supplyLowIn, powerUpIn} = 2'h0;
		req = '{OP_READ, 22'h000000, 16'h0000};
		nFail = 0;
		checksDone = 0;
		tick(6);
		rst_n = 1'b1;
		check("idle pins", 16'h003A, 16'({flashCtl, highVoltReset, writeProtectN, inRegion}));
		tRegion();
		tProtect();
		tInhibit();
		completeRun();
	end
endmodule : tb_fps_host
